// ### bench/fpcr_top_props.sv
// Concurrent checks on the bus, command, option and range check ports
`default_nettype none
module fpcr_top_props
(
	input wire logic        i_clk,
	input wire logic        i_arst_n,
	input wire logic        o_avs_waitrequest,
	input wire logic        o_ready,
	input wire logic        o_cfg_req,
	input wire logic [17:0] o_cfg_addr,
	input wire logic        i_cfg_ack,
	input wire logic [7:0]  i_cfg_data,
	input wire logic        i_cfg_dbe,
	input wire logic        o_cmd_start,
	input wire logic        o_cmd_busy,
	input wire logic        i_cmd_done,
	input wire logic        i_chk_valid,
	input wire logic        o_chk_done,
	input wire logic        o_chk_deny,
	input wire logic [7:0]  o_option_bits
);
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_arst_n);
	// ==========
	// Register bus
	property p_ack_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
	a_ack_one: assert property (p_ack_one) else $error("long ack");
	property p_ready_wait; !o_ready |-> o_avs_waitrequest; endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ack before load");
	// ==========
	// Option load, then frozen
	property p_opt_load; i_cfg_ack && o_cfg_req && o_cfg_addr == 18'h3ff0e |=>
		o_option_bits == ($past(i_cfg_dbe) ? 8'hff : $past(i_cfg_data)); endproperty
	a_opt_load: assert property (p_opt_load) else $error("option load");
	property p_opt_stable; o_ready |=> $stable(o_option_bits); endproperty
	a_opt_stable: assert property (p_opt_stable) else $error("option changed");
	// ==========
	// Command launch and finish
	property p_start_busy; o_cmd_start |-> o_cmd_busy ##1 !o_cmd_start; endproperty
	a_start_busy: assert property (p_start_busy) else $error("start pulse");
	property p_done_idle; o_cmd_busy && i_cmd_done |=> !o_cmd_busy; endproperty
	a_done_idle: assert property (p_done_idle) else $error("busy after done");
	property p_busy_hold; o_cmd_busy && !i_cmd_done |=> o_cmd_busy && !o_cmd_start; endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
	// ==========
	// Range check answer
	property p_chk_done; i_chk_valid |=> o_chk_done; endproperty
	a_chk_done: assert property (p_chk_done) else $error("no check answer");
	property p_deny_done; o_chk_deny |-> o_chk_done && $past(i_chk_valid); endproperty
	a_deny_done: assert property (p_deny_done) else $error("stray deny");
endmodule // fpcr_top_props

bind fpcr_top fpcr_top_props chk (.i_clk, .i_arst_n, .o_avs_waitrequest, .o_ready, .o_cfg_req,
	.o_cfg_addr, .i_cfg_ack, .i_cfg_data, .i_cfg_dbe, .o_cmd_start, .o_cmd_busy, .i_cmd_done,
	.i_chk_valid, .o_chk_done, .o_chk_deny, .o_option_bits);
`default_nettype wire

// ### bench/fpcr_top_tb.sv
// Random and corner tests of the protection, option and command object slice
`default_nettype none
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) \
	begin err_total++; $display("BAD %0t %s", $time, m); end end
module fpcr_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        i_clk, i_arst_n, i_avs_read, i_avs_write, i_cfg_ack, i_cfg_dbe, i_cmd_done;
	logic        i_res_we, i_chk_valid, i_chk_blk_erase, o_avs_waitrequest, o_cfg_req;
	logic        o_cmd_start, o_cmd_busy, o_chk_done, o_chk_deny, o_ready, p_open, viol;
	logic [2:0]  i_eng_rd_idx, i_res_idx;
	logic [3:0]  i_avs_byteenable, p_size;
	logic [4:0]  i_avs_address;
	logic [7:0]  i_cfg_data, o_option_bits, q;
	logic [15:0] o_eng_rd_data, i_res_data, w;
	logic [15:0] ws [8];
	logic [17:0] o_cfg_addr, i_chk_addr;
	logic [31:0] i_avs_writedata, o_avs_readdata;
	int          err_total, n_checks;

	fpcr_top uut (.i_clk, .i_arst_n, .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
		.i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_cfg_req, .o_cfg_addr,
		.i_cfg_ack, .i_cfg_data, .i_cfg_dbe, .o_cmd_start, .o_cmd_busy, .i_cmd_done,
		.i_eng_rd_idx, .o_eng_rd_data, .i_res_we, .i_res_idx, .i_res_data, .i_chk_valid,
		.i_chk_addr, .i_chk_blk_erase, .o_chk_done, .o_chk_deny, .o_option_bits, .o_ready);

	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	// ==========
	// Verdict
	task automatic print_verdict(input logic to);
		if (to)
			err_total++;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========
	// Bus master: request held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int n;
		@(posedge i_clk);
		i_avs_address <= a;
		i_avs_writedata <= {24'h0, d};
		i_avs_read <= !wr;
		i_avs_write <= wr;
		for (n = 0; n < 200; n++)
		begin
			@(posedge i_clk);
			if (o_avs_waitrequest === 1'b0)
				break;
		end
		if (n == 200)
			print_verdict(1'b1);
		q = o_avs_readdata[7:0];
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
	endtask

	// Answers one configuration byte fetch, matched on its address
	task automatic cfg(input logic [17:0] a, input logic [7:0] d, input logic e);
		int n;
		for (n = 0; n < 100 && !(o_cfg_req === 1'b1 && o_cfg_addr === a); n++)
			@(posedge i_clk);
		if (n == 100)
			print_verdict(1'b1);
		i_cfg_ack <= 1'b1;
		i_cfg_data <= d;
		i_cfg_dbe <= e;
		@(posedge i_clk);
		i_cfg_ack <= 1'b0;
	endtask

	task automatic do_reset(input logic e);
		logic [7:0] pd, od;
		pd = 8'($urandom);
		od = 8'($urandom);
		i_arst_n <= 1'b0;
		repeat (4) @(posedge i_clk);
		i_arst_n <= 1'b1;
		cfg(18'h3ff0d, pd, e);
		cfg(18'h3ff0e, od, e);
		p_open = e ? 1'b0 : pd[7];
		p_size = e ? 4'hf : pd[3:0];
		viol = 1'b0;
		bus(1'b0, 5'h10, 8'h0);
		`CHK(q, e ? 8'hff : od, "option load")
		bus(1'b1, 5'h10, ~q);
		bus(1'b0, 5'h10, 8'h0);
		`CHK(q, e ? 8'hff : od, "option write")
		bus(1'b0, 5'h14, 8'h0);
		`CHK(q, {p_open, 3'h0, p_size}, "prot load")
	endtask

	// One protection write, then one range check against the model
	task automatic prot_step(input logic [7:0] d, input logic be);
		logic [17:0] a;
		logic        blk, deny;
		i_avs_byteenable <= {3'h0, be};
		bus(1'b1, 5'h14, d);
		i_avs_byteenable <= 4'h1;
		// Refused whole when it would reopen or shrink
		if (be && !(d[7] && !p_open) && d[3:0] >= p_size)
		begin
			p_open = d[7];
			p_size = d[3:0];
		end
		bus(1'b0, 5'h14, 8'h0);
		`CHK(q, {p_open, 3'h0, p_size}, "prot write")
		a = 18'h4380 + 18'($urandom % 32'h1200);
		blk = ($urandom % 4) == 0;
		deny = !p_open && (blk || (a < 18'h4400 + 18'h100 * ({14'h0, p_size} + 18'h1)
			&& a >= 18'h4400));
		@(posedge i_clk);
		i_chk_valid <= 1'b1;
		i_chk_addr <= a;
		i_chk_blk_erase <= blk;
		@(posedge i_clk);
		i_chk_valid <= 1'b0;
		@(posedge i_clk);
		`CHK({o_chk_done, o_chk_deny}, {1'b1, deny}, "range check")
		viol = viol | deny;
		bus(1'b0, 5'h09, 8'h0);
		`CHK({q[7], q[5]}, {1'b1, viol}, "status")
		bus(1'b1, 5'h09, 8'h20);
		viol = 1'b0;
	endtask

	// ==========
	// Main sequence
	initial
	begin
		{i_avs_read, i_avs_write, i_cfg_ack, i_cfg_dbe, i_cmd_done, i_res_we} = '0;
		{i_chk_valid, i_chk_blk_erase, i_arst_n, i_eng_rd_idx, i_res_idx} = '0;
		{i_avs_address, i_cfg_data, i_res_data, i_chk_addr, i_avs_writedata} = '0;
		i_avs_byteenable = 4'h1;
		err_total = 0;
		n_checks = 0;
		void'($urandom(32'hdcd5));
		// First pass loads with a double-bit error, second with random bytes
		for (int k = 0; k < 2; k++)
		begin
			do_reset(k == 0);
			for (int a = 12; a < 19; a++)
			begin
				if (a == 16)
					continue;
				bus(1'b1, 5'(a), 8'hff);
				bus(1'b0, 5'(a), 8'h0);
				`CHK(q, 8'h00, "reserved")
			end
			for (int j = 0; j < 14; j++)
				prot_step(j == 0 ? 8'h03 : j == 1 ? 8'h83 : 8'($urandom), 1'($urandom % 5 != 0));
			$display("test reset and protection pass %0d done", k);
		end
		for (int i = 0; i < 8; i++)
		begin
			ws[i] = 16'($urandom);
			ws[0][7:2] = 6'h0;
			bus(1'b1, 5'h08, 8'(i));
			bus(1'b1, 5'h0a, ws[i][15:8]);
			bus(1'b1, 5'h0b, ws[i][7:0]);
		end
		for (int i = 0; i < 8; i++)
		begin
			w = (i > 5) ? 16'h0 : ws[i];
			bus(1'b1, 5'h08, 8'(i));
			bus(1'b0, 5'h0a, 8'h0);
			`CHK(q, w[15:8], "cmd high")
			bus(1'b0, 5'h0b, 8'h0);
			`CHK(q, w[7:0], "cmd low")
			i_eng_rd_idx <= 3'(i);
			repeat (2) @(posedge i_clk);
			`CHK(o_eng_rd_data, w, "engine read")
		end
		$display("test command load done");
		bus(1'b1, 5'h09, 8'h80);
		repeat (2) @(posedge i_clk);
		`CHK(o_cmd_busy, 1'b1, "launch")
		bus(1'b1, 5'h08, 8'h0);
		bus(1'b1, 5'h0a, ~ws[0][15:8]);
		bus(1'b0, 5'h0a, 8'h0);
		`CHK(q, ws[0][15:8], "locked")
		bus(1'b0, 5'h09, 8'h0);
		`CHK(q[7], 1'b0, "flag low")
		w = 16'($urandom);
		i_res_we <= 1'b1;
		i_res_idx <= 3'h2;
		i_res_data <= w;
		@(posedge i_clk);
		i_res_we <= 1'b0;
		i_cmd_done <= 1'b1;
		@(posedge i_clk);
		i_cmd_done <= 1'b0;
		bus(1'b0, 5'h09, 8'h0);
		`CHK({q[7], o_cmd_busy}, 2'b10, "finish")
		bus(1'b1, 5'h08, 8'h2);
		bus(1'b0, 5'h0a, 8'h0);
		`CHK(q, w[15:8], "result")
		$display("test command run done");
		print_verdict(1'b0);
	end
endmodule // fpcr_top_tb
`default_nettype wire

// ### hdl/fpcr_cmd_mem.v
// Six-word command object storage with byte writes and registered reads
`include "fpcr_consts.vh"
`default_nettype none

module fpcr_cmd_mem
(
	input  wire        i_clk,
	input  wire        i_arst_n,
	input  wire        i_wr_hi,
	input  wire        i_wr_lo,
	input  wire [2:0]  i_wr_idx,
	input  wire [15:0] i_wr_data,
	input  wire [2:0]  i_rd_a_idx,
	input  wire [2:0]  i_rd_b_idx,
	output reg  [15:0] o_rd_a_data,
	output reg  [15:0] o_rd_b_data
);

	wire [15:0] word_w [0:`FPCR_CMD_WORDS-1];

	// ========================================================
	// Storage entries
	genvar g;
	generate
		for (g = 0; g < `FPCR_CMD_WORDS; g = g + 1)
		begin : g_word
			// Each entry owns its register, so no array is driven from several processes
			localparam [2:0] WIDX = g;
			reg [15:0] word_reg;
			assign word_w[g] = word_reg;
			always @(posedge i_clk or negedge i_arst_n)
			begin
				if (!i_arst_n)
					word_reg <= `FPCR_RST_WORD;
				else if (i_wr_idx == WIDX)
				begin
					// R12 independent bytes
					if (i_wr_hi)
						word_reg[15:8] <= i_wr_data[15:8];
					if (i_wr_lo)
						word_reg[7:0] <= i_wr_data[7:0];
				end
			end
		end
	endgenerate

	// ========================================================
	// Read ports
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_rd_a_data <= `FPCR_RST_WORD;
			o_rd_b_data <= `FPCR_RST_WORD;
		end
		else
		begin
			// R16 unimplemented words read zero
			o_rd_a_data <= (i_rd_a_idx > `FPCR_IDX_LAST_WORD) ? `FPCR_RST_WORD
				: word_w[i_rd_a_idx];
			o_rd_b_data <= (i_rd_b_idx > `FPCR_IDX_LAST_WORD) ? `FPCR_RST_WORD
				: word_w[i_rd_b_idx];
		end
	end

endmodule // fpcr_cmd_mem
`default_nettype wire

// ### hdl/fpcr_consts.vh
// Constants for the flash protection and command object register slice
// Operation
// R1 - Protection register writes that would reduce protection leave it unchanged
// R2 - Size field only takes a value larger than the one held; the code also takes a write of the same value
// R3 - Open bit may go from 1 to 0 only, never back
// R4 - Open bit at 1 disables protection whatever the size field holds
// R5 - Reset sequence loads protection register from configuration byte in program flash
// R6 - Double-bit error on that load clears open bit, sets all size bits
// R7 - Program or erase into protected data flash is refused, violation flag set
// R8 - Whole-block data flash erase refused while any sector is protected
// R9 - Size field selects range from base, 256 bytes times value plus one
// R10 - Bit 7 is open bit; 0 blocks program and erase in range
// R11 - Command object is six 16-bit words selected by a 3-bit index
// R12 - High and low bytes of indexed word are accessed separately
// R13 - Writing 1 to completion flag clears it and launches the command
// R14 - Command object fields locked while completion flag is 0
// R15 - Finished command sets completion flag; results readable after that
// R16 - Index 6 and 7 discard writes and read 0x0000
// R17 - Word 0 high is command code, low holds address 17:16, then address, data
// R18 - Reserved test registers read zero and ignore writes
// R19 - Option register is readable and never changed by a write
// R20 - Reset sequence loads option register from option byte in program flash
// R21 - Double-bit error on that load sets every option bit
// R22 - Option bits 7 to 0 are general nonvolatile bits for the chip
// R23 - Writes to the command object are ignored while a command runs
// R24 - High and low byte accesses go to the word chosen by the index
`ifndef FPCR_CONSTS_VH
`define FPCR_CONSTS_VH

// Register indices; byte address is four times the index
`define FPCR_IDX_CMD_INDEX   5'h08
`define FPCR_IDX_STATUS      5'h09
`define FPCR_IDX_CMD_HIGH    5'h0a
`define FPCR_IDX_CMD_LOW     5'h0b
`define FPCR_IDX_RSV_A       5'h0c
`define FPCR_IDX_RSV_B       5'h0d
`define FPCR_IDX_RSV_C       5'h0e
`define FPCR_IDX_RSV_D       5'h0f
`define FPCR_IDX_OPTION      5'h10
`define FPCR_IDX_RSV_E       5'h11
`define FPCR_IDX_RSV_F       5'h12
`define FPCR_IDX_PROT        5'h14

// Field positions
`define FPCR_BIT_OPEN        7
`define FPCR_BIT_COMPLETE    7
`define FPCR_BIT_VIOL        5

// Reset and double-bit error load values
`define FPCR_RST_OPEN        1'b1
`define FPCR_RST_SIZE        4'h0
`define FPCR_ERR_SIZE        4'hf
`define FPCR_RST_OPTION      8'hff
`define FPCR_RST_INDEX       3'h0
`define FPCR_RST_WORD        16'h0000

// Configuration field addresses and data flash geometry
`define FPCR_CFG_ADDR_PROT   18'h3ff0d
`define FPCR_CFG_ADDR_OPTION 18'h3ff0e
`define FPCR_DF_BASE         18'h04400
`define FPCR_DF_STEP         18'h00100
`define FPCR_CMD_WORDS       6
`define FPCR_IDX_LAST_WORD   3'h5

// Bus answer latency in cycles from the request being seen
`define FPCR_BUS_LATENCY     2

`endif

// ### hdl/fpcr_prot_chk.v
// Data flash protection range check for program and erase requests
`include "fpcr_consts.vh"
`default_nettype none

module fpcr_prot_chk
(
	input  wire        i_clk,
	input  wire        i_arst_n,
	input  wire        i_open,
	input  wire [3:0]  i_size,
	input  wire        i_chk_valid,
	input  wire [17:0] i_chk_addr,
	input  wire        i_chk_blk_erase,
	output reg         o_done,
	output reg         o_deny
);

	wire [17:0] limit;
	wire        in_range;

	// R9 range end, exclusive
	assign limit    = `FPCR_DF_BASE + {6'h00, i_size, 8'h00} + `FPCR_DF_STEP;
	assign in_range = (i_chk_addr >= `FPCR_DF_BASE) && (i_chk_addr < limit);

	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			o_done <= 1'b0;
			o_deny <= 1'b0;
		end
		else
		begin
			o_done <= i_chk_valid;
			// R4 R10 open bit disables; R8 block erase; R7 range hit
			o_deny <= i_chk_valid && !i_open && (i_chk_blk_erase || in_range);
		end
	end

endmodule // fpcr_prot_chk
`default_nettype wire

// ### hdl/fpcr_top.v
// Flash protection, option and command object register slice with Avalon-MM slave
`include "fpcr_consts.vh"
`default_nettype none

module fpcr_top
(
	input  wire        i_clk,
	input  wire        i_arst_n,
	// Avalon-MM slave, word addressed
	input  wire [4:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	// Configuration field reads during the reset sequence
	output reg         o_cfg_req,
	output reg  [17:0] o_cfg_addr,
	input  wire        i_cfg_ack,
	input  wire [7:0]  i_cfg_data,
	input  wire        i_cfg_dbe,
	// Command engine side
	output reg         o_cmd_start,
	output reg         o_cmd_busy,
	input  wire        i_cmd_done,
	input  wire [2:0]  i_eng_rd_idx,
	output wire [15:0] o_eng_rd_data,
	input  wire        i_res_we,
	input  wire [2:0]  i_res_idx,
	input  wire [15:0] i_res_data,
	// Protection check for program and erase
	input  wire        i_chk_valid,
	input  wire [17:0] i_chk_addr,
	input  wire        i_chk_blk_erase,
	output wire        o_chk_done,
	output wire        o_chk_deny,
	// Option bits for chip level use
	output reg  [7:0]  o_option_bits,
	output reg         o_ready
);

	// ========================================================
	// Reset sequence states
	localparam [2:0] ST_LD_PROT = 3'b001;
	localparam [2:0] ST_LD_OPT  = 3'b010;
	localparam [2:0] ST_READY   = 3'b100;

	reg  [2:0]  state_reg;
	reg  [2:0]  state_next;
	reg         open_reg;
	reg  [3:0]  size_reg;
	reg  [2:0]  index_reg;
	reg         complete_reg;
	reg         viol_reg;
	reg         pend_reg;
	reg  [31:0] rdata_next;
	wire        req;
	wire        commit_wr;
	wire        be0;
	wire [7:0]  wd;
	wire        prot_wr;
	wire        reduce;
	wire        launch;
	wire        viol_clr;
	wire        bus_wr_hi;
	wire        bus_wr_lo;
	wire        mem_wr_hi;
	wire        mem_wr_lo;
	wire [2:0]  mem_wr_idx;
	wire [15:0] mem_wr_data;
	wire [15:0] bus_word;

	assign req       = i_avs_read || i_avs_write;
	assign commit_wr = i_avs_write && !o_avs_waitrequest;
	assign be0       = i_avs_byteenable[0];
	assign wd        = i_avs_writedata[7:0];

	// ========================================================
	// Reset sequence loading protection and option bytes
	always @*
	begin
		state_next = state_reg;
		case (state_reg)
			ST_LD_PROT:
			begin
				if (i_cfg_ack)
					state_next = ST_LD_OPT;
			end
			ST_LD_OPT:
			begin
				if (i_cfg_ack)
					state_next = ST_READY;
			end
			ST_READY:
				state_next = ST_READY;
			default:
				state_next = ST_LD_PROT;
		endcase
	end

	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			state_reg     <= ST_LD_PROT;
			o_cfg_req     <= 1'b1;
			o_cfg_addr    <= `FPCR_CFG_ADDR_PROT;
			o_option_bits <= `FPCR_RST_OPTION;
			o_ready       <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			o_ready   <= (state_next == ST_READY);
			o_cfg_req <= (state_next != ST_READY);
			if (state_next == ST_LD_OPT)
				o_cfg_addr <= `FPCR_CFG_ADDR_OPTION;
			// R20 option byte load
			if (state_reg == ST_LD_OPT && i_cfg_ack)
			begin
				// R21 double-bit error sets all bits
				if (i_cfg_dbe)
					o_option_bits <= `FPCR_RST_OPTION;
				else
					o_option_bits <= i_cfg_data;
			end
		end
	end

	// ========================================================
	// Data flash protection register
	// A write is taken whole or not at all, so a mixed write cannot weaken anything.
	assign prot_wr   = commit_wr && be0 && (i_avs_address == `FPCR_IDX_PROT);
	// R1 R2 R3 reduction test
	assign reduce    = (!open_reg && wd[`FPCR_BIT_OPEN]) || (wd[3:0] < size_reg);

	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			open_reg <= `FPCR_RST_OPEN;
			size_reg <= `FPCR_RST_SIZE;
		end
		else if (state_reg == ST_LD_PROT && i_cfg_ack)
		begin
			// R5 load; R6 double-bit error protects everything
			if (i_cfg_dbe)
			begin
				open_reg <= 1'b0;
				size_reg <= `FPCR_ERR_SIZE;
			end
			else
			begin
				open_reg <= i_cfg_data[`FPCR_BIT_OPEN];
				size_reg <= i_cfg_data[3:0];
			end
		end
		else if (prot_wr && !reduce)
		begin
			// R1 add-only update
			open_reg <= open_reg & wd[`FPCR_BIT_OPEN];
			size_reg <= wd[3:0];
		end
	end

	// ========================================================
	// Index, completion and violation flags
	assign launch   = commit_wr && be0 && complete_reg && (i_avs_address == `FPCR_IDX_STATUS)
		&& wd[`FPCR_BIT_COMPLETE];
	assign viol_clr = commit_wr && be0 && (i_avs_address == `FPCR_IDX_STATUS)
		&& wd[`FPCR_BIT_VIOL];

	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			index_reg    <= `FPCR_RST_INDEX;
			complete_reg <= 1'b1;
			viol_reg     <= 1'b0;
			o_cmd_start  <= 1'b0;
			o_cmd_busy   <= 1'b0;
		end
		else
		begin
			if (commit_wr && be0 && i_avs_address == `FPCR_IDX_CMD_INDEX)
				index_reg <= wd[2:0];
			o_cmd_start <= launch;
			// R13 launch clears flag; R15 engine finish sets it
			if (launch)
				complete_reg <= 1'b0;
			else if (i_cmd_done && !complete_reg)
				complete_reg <= 1'b1;
			o_cmd_busy <= launch || (o_cmd_busy && !i_cmd_done);
			// R7 violation set wins over clear
			if (o_chk_deny)
				viol_reg <= 1'b1;
			else if (viol_clr)
				viol_reg <= 1'b0;
		end
	end

	// ========================================================
	// Command object storage
	// R14 R23 bus writes only while no command runs; R16 words 6 and 7 dropped
	assign bus_wr_hi   = commit_wr && be0 && complete_reg
		&& (i_avs_address == `FPCR_IDX_CMD_HIGH) && (index_reg <= `FPCR_IDX_LAST_WORD);
	assign bus_wr_lo   = commit_wr && be0 && complete_reg
		&& (i_avs_address == `FPCR_IDX_CMD_LOW) && (index_reg <= `FPCR_IDX_LAST_WORD);
	// Engine result writes only happen while the flag is low, so they never meet a bus write
	assign mem_wr_hi   = (i_res_we && !complete_reg) || bus_wr_hi;
	assign mem_wr_lo   = (i_res_we && !complete_reg) || bus_wr_lo;
	// R24 bus side follows the index register
	assign mem_wr_idx  = complete_reg ? index_reg : i_res_idx;
	assign mem_wr_data = complete_reg ? {wd, wd} : i_res_data;

	// R11 R17 six words, word 0 holds code and upper address
	fpcr_cmd_mem u_mem
	(
		.i_clk       (i_clk),
		.i_arst_n    (i_arst_n),
		.i_wr_hi     (mem_wr_hi),
		.i_wr_lo     (mem_wr_lo),
		.i_wr_idx    (mem_wr_idx),
		.i_wr_data   (mem_wr_data),
		.i_rd_a_idx  (index_reg),
		.i_rd_b_idx  (i_eng_rd_idx),
		.o_rd_a_data (bus_word),
		.o_rd_b_data (o_eng_rd_data)
	);

	fpcr_prot_chk u_chk
	(
		.i_clk           (i_clk),
		.i_arst_n        (i_arst_n),
		.i_open          (open_reg),
		.i_size          (size_reg),
		.i_chk_valid     (i_chk_valid),
		.i_chk_addr      (i_chk_addr),
		.i_chk_blk_erase (i_chk_blk_erase),
		.o_done          (o_chk_done),
		.o_deny          (o_chk_deny)
	);

	// ========================================================
	// Read data selection
	always @*
	begin
		rdata_next = 32'h0000_0000;
		case (i_avs_address)
			`FPCR_IDX_CMD_INDEX:
				rdata_next[2:0] = index_reg;
			`FPCR_IDX_STATUS:
			begin
				rdata_next[`FPCR_BIT_COMPLETE] = complete_reg;
				rdata_next[`FPCR_BIT_VIOL]     = viol_reg;
			end
			`FPCR_IDX_CMD_HIGH:
				rdata_next[7:0] = bus_word[15:8];
			`FPCR_IDX_CMD_LOW:
				rdata_next[7:0] = bus_word[7:0];
			// R19 R22 option bits read only
			`FPCR_IDX_OPTION:
				rdata_next[7:0] = o_option_bits;
			`FPCR_IDX_PROT:
			begin
				rdata_next[`FPCR_BIT_OPEN] = open_reg;
				rdata_next[3:0]            = size_reg;
			end
			// R18 reserved test registers and unmapped read zero
			default:
				rdata_next = 32'h0000_0000;
		endcase
	end

	// ========================================================
	// Avalon answer: one cycle to settle the word read, then waitrequest low
	always @(posedge i_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			pend_reg          <= 1'b0;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
		end
		else
		begin
			pend_reg          <= req && o_avs_waitrequest && !pend_reg && o_ready;
			o_avs_waitrequest <= !pend_reg;
			if (pend_reg)
				o_avs_readdata <= rdata_next;
		end
	end

endmodule // fpcr_top
`default_nettype wire
